/* bench/serial_comm_unit_chk.sv */
`timescale 1ns/1ns
module serial_comm_unit_chk #(
  parameter int BAUD_W = 8
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq,
  input wire logic        txd,
  input wire logic        rxd,
  input wire logic        sck_in,
  input wire logic        sck_out,
  input wire logic        sck_oe
);
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [2:0] age;
  logic [2:0] clr_age;
  logic       wr_ack;
  logic       cfg_wr;
  logic       clr_ack;
  assign wr_ack = write & ~waitrequest;
  assign cfg_wr = wr_ack & (address == serial_pkg::MODE_OFS || address == serial_pkg::CTRL_OFS);
  assign clr_ack = (read & ~waitrequest & address == serial_pkg::STAT_OFS) |
                   (wr_ack & address == serial_pkg::MASK_OFS);
  // Pins follow a setting only a few clocks later, so judge them once settled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      age <= 3'h0;
      clr_age <= 3'h7;
    end else begin
      if (wr_ack && address == serial_pkg::MODE_OFS) mode_q <= writedata[7:0];
      if (wr_ack && address == serial_pkg::CTRL_OFS) ctrl_q <= writedata[7:0];
      age <= cfg_wr ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
      clr_age <= clr_ack ? 3'h0 : (clr_age == 3'h7 ? clr_age : clr_age + 3'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    $rose(read || write);
  endsequence
  sequence s_ans;
    waitrequest ##1 !waitrequest ##1 waitrequest;
  endsequence
  a_wait_two_edges: assert property (s_req |-> s_ans)
    else $error("bus answer off its slot");
  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_ack_needs_req: assert property (!waitrequest |-> read || write)
    else $error("answer without request");
  a_unmapped_zero: assert property (read && address == 5'h1c && !waitrequest |-> readdata == 32'h0)
    else $error("hole read not zero");
  a_pin_unused: assert property (age == 3'h7 && !mode_q[7] && ctrl_q[1:0] == 2'b00 |-> !sck_oe)
    else $error("clock pin driven while unused");
  a_sck_driven: assert property (age == 3'h7 && !ctrl_q[1] && (mode_q[7] || ctrl_q[0]) |-> sck_oe)
    else $error("clock pin not driven");
  a_sck_input: assert property (age == 3'h7 && ctrl_q[1] |-> !sck_oe)
    else $error("clock pin driven while input");
  a_clk_half_bit: assert property ($rose(sck_out) && sck_oe && age == 3'h7 |-> (sck_out || age != 3'h7)[*8])
    else $error("clock high phase too short");
  a_start_held: assert property ($fell(txd) |-> !txd[*8])
    else $error("start bit too short");
  a_irq_drop: assert property ($fell(irq) |-> clr_age < 3'h4)
    else $error("irq fell without clear");
endmodule
bind serial_comm_unit serial_comm_unit_chk #(.BAUD_W(BAUD_W)) u_serial_comm_unit_chk (
  .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .txd(txd), .rxd(rxd), .sck_in(sck_in),
  .sck_out(sck_out), .sck_oe(sck_oe));

/* bench/serial_comm_unit_tb.sv */
`timescale 1ns/1ns
module serial_comm_unit_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, irq, txd, rxd, sck_in, sck_out, sck_oe;
  logic [31:0] q;
  logic [12:0] got;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [4:0]  ofs [6] = '{serial_pkg::MODE_OFS, serial_pkg::CTRL_OFS, serial_pkg::STAT_OFS,
                           serial_pkg::MASK_OFS, serial_pkg::BAUD_OFS, 5'h1c};
  // Mode, control, expected clock pin enable
  logic [16:0] tbl [7] = '{17'h00000, 17'h00003, 17'h00004, 17'h10001, 17'h1f803, 17'h10004, 17'h10006};

  always #5 clk = ~clk;

  serial_comm_unit #(.BAUD_W(8)) u_serial_comm_unit (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .txd(txd), .rxd(rxd),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe));
  serial_peer u_serial_peer (.txd(txd), .rxd(rxd), .sck_in(sck_in));

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= ~w;
    writedata <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      fail_count++;
      give_verdict();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Line image from the start bit on; f is {seven, parity, multi, two_stop}
  function automatic logic [12:0] frame(input logic [3:0] f, input logic [7:0] d);
    logic [12:0] v;
    int          n;
    v = 13'h1ffe;
    n = f[3] ? 7 : 8;
    for (int i = 0; i < n; i++) v[i + 1] = d[i];
    if (f[1]) v[n + 1] = 1'b0;
    else if (f[2]) v[n + 1] = ^(d & (f[3] ? 8'h7f : 8'hff));
    return v;
  endfunction

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ofs[k], 8'h00);
      chk("reset", 32'h0, q & 32'hff);
    end
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, serial_pkg::MODE_OFS, tbl[k][16:9]);
      bus(1'b1, serial_pkg::CTRL_OFS, tbl[k][8:1]);
      repeat (6) @(posedge clk);
      chk("sck_oe", {31'h0, tbl[k][0]}, {31'h0, sck_oe});
    end
    bus(1'b1, serial_pkg::MODE_OFS, 8'h00);
    bus(1'b1, serial_pkg::CTRL_OFS, 8'h30);
    bus(1'b1, serial_pkg::MASK_OFS, 8'h02);
    // Full duplex: both directions at the same time
    fork
      bus(1'b1, serial_pkg::TXD_OFS, 8'ha5);
      u_serial_peer.catch_frame(got, 160);
      u_serial_peer.send({4'hf, 8'h3c, 1'b0}, 10, 160);
    join
    chk("tx_frame", {19'h0, frame(4'h0, 8'ha5)}, {19'h0, got});
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, serial_pkg::STAT_OFS, 8'h00);
    chk("status", 32'h3, q & 32'h3);
    repeat (3) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    bus(1'b0, serial_pkg::RXD_OFS, 8'h00);
    chk("rx_data", 32'h3c, q & 32'hff);
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, serial_pkg::MODE_OFS, {1'b0, k[3], k[2], 1'b0, k[0], k[1], 2'b00});
      fork
        bus(1'b1, serial_pkg::TXD_OFS, 8'h5a ^ k[7:0]);
        u_serial_peer.catch_frame(got, 160);
      join
      chk("format", {19'h0, frame(k[3:0], 8'h5a ^ k[7:0])}, {19'h0, got});
    end
    // Receiver off: in synchronous mode it would run free and fill the buffer
    bus(1'b1, serial_pkg::CTRL_OFS, 8'h20);
    bus(1'b1, serial_pkg::MODE_OFS, 8'hfc);
    fork
      bus(1'b1, serial_pkg::TXD_OFS, 8'h5a);
      u_serial_peer.catch_frame(got, 160);
    join
    chk("sync_tx", 32'h0000_1f5a, {19'h0, got});
    bus(1'b1, serial_pkg::MODE_OFS, 8'h00);
    bus(1'b1, serial_pkg::CTRL_OFS, 8'h30);
    bus(1'b0, serial_pkg::STAT_OFS, 8'h00);
    // Short low pulse must not start a character
    u_serial_peer.send(13'h0, 1, 40);
    repeat (20) @(posedge clk);
    u_serial_peer.send({4'hf, 8'h81, 1'b0}, 10, 160);
    u_serial_peer.send({4'hf, 8'h7e, 1'b0}, 10, 160);
    bus(1'b0, serial_pkg::RXD_OFS, 8'h00);
    chk("rx_kept", 32'h81, q & 32'hff);
    bus(1'b0, serial_pkg::STAT_OFS, 8'h00);
    chk("overrun", 32'h6, q & 32'h6);
    bus(1'b1, serial_pkg::CTRL_OFS, 8'h12);
    u_serial_peer.run = 1'b1;
    u_serial_peer.send({4'hf, 8'h96, 1'b0}, 10, 2000);
    u_serial_peer.run = 1'b0;
    bus(1'b0, serial_pkg::RXD_OFS, 8'h00);
    chk("ext_rx", 32'h96, q & 32'hff);
    give_verdict();
  end
endmodule

/* bench/serial_peer.sv */
`timescale 1ns/1ns
module serial_peer (
  input  wire logic txd,
  output logic      rxd,
  output logic      sck_in
);
  logic run;
  initial begin
    rxd = 1'b1;
    sck_in = 1'b0;
    run = 1'b0;
  end
  // 16x clock only within frames, held low between them
  always begin
    #62 sck_in = run;
    #63 sck_in = 1'b0;
  end
  task automatic send(input logic [12:0] v, input int n, input int bit_ns);
    #3;
    for (int i = 0; i < n; i++) begin
      rxd = v[i];
      #(bit_ns);
    end
    rxd = 1'b1;
  endtask
  task automatic catch_frame(output logic [12:0] v, input int bit_ns);
    int i;
    v = 'x;
    for (i = 0; i < 3000 && txd !== 1'b0; i++) #1;
    if (i < 3000) begin
      #(bit_ns / 2);
      for (int j = 0; j < 13; j++) begin
        v[j] = txd;
        #(bit_ns);
      end
    end
  endtask
endmodule

/* core/edge_sync.sv */
`timescale 1ns/1ns
module edge_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Resets high so an idle line reads as mark
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;
endmodule

/* core/serial_comm_unit.sv */
// Function
// - Synchronous mode always sends and takes eight data bits, no parity, no stop.
// - Synchronous receive reports only overrun errors.
// - Synchronous internal clock: baud generator clocks the unit, clock pin driven out.
// - Synchronous external clock: shift on the incoming clock, baud generator idle.
// - Mode bit 7 set selects synchronous mode, ignoring format bits; clear selects async.
// - Async format: bit 6 seven bits, bit 5 parity, bit 3 two stops, bit 2 multiprocessor.
// - Async with control bits 1:0 at zero: internal clock, clock pin unused.
// - Async with control 1:0 at 01: drive clock pin at the bit rate.
// - Synchronous: control bit 1 clear drives clock out, set takes it in.
// - Async characters framed by start and stop, resynchronised every character.
// - Transmitter and receiver run independently for full duplex.
// - Each direction has one buffered word besides its shift register.
// - Line idles high; a fall to low starts a character.
// - Send start low, data LSB first, optional parity, then high stop bits.
// - Receive bit timing aligns to the start bit falling edge.
// - Sample each bit on the eighth of sixteen ticks, the bit centre.
// - Sixteen async formats selected through the mode register.
`timescale 1ns/1ns
module serial_comm_unit #(
  parameter int BAUD_W = 8
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  output logic             txd,
  input  wire logic        rxd,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_type;

  // Register file
  logic [7:0]                  mode_reg, mode_next;
  logic [7:0]                  ctrl_reg, ctrl_next;
  logic [7:0]                  mask_reg, mask_next;
  logic [BAUD_W-1:0]           baud_reg, baud_next;
  logic [serial_pkg::NUM_EV-1:0] status_reg, status_next;
  logic [7:0]                  hold_reg, hold_next;
  logic                        hold_full_reg, hold_full_next;
  logic [7:0]                  rxbuf_reg, rxbuf_next;
  logic                        rx_full_reg, rx_full_next;
  logic [31:0]                 readdata_reg, readdata_next;
  logic                        wait_reg, wait_next;
  logic                        ack_reg, ack_next;
  logic                        irq_reg, irq_next;

  // Clock generation
  logic [BAUD_W-1:0]           bdiv_reg, bdiv_next;
  logic [3:0]                  ph_reg, ph_next;
  serial_pkg::pins_type        pins_reg, pins_next;

  // Receiver
  rx_state_type                rst_reg, rst_next;
  logic [7:0]                  rsh_reg, rsh_next;
  logic [3:0]                  rcnt_reg, rcnt_next;
  logic [3:0]                  tcnt_reg, tcnt_next;
  logic                        rpar_reg, rpar_next;
  logic                        rdone_reg, rdone_next;
  logic                        rfe_reg, rfe_next;
  logic                        rpe_reg, rpe_next;

  serial_pkg::fmt_type         fmt;
  logic                        ext, te, re;
  logic                        rx_lvl, rx_fall;
  logic                        sck_rise, sck_fall;
  logic                        tick, adv, samp, smp, bit_in;
  logic                        acc, wr, rd_stat;
  logic                        take, tx_done, tx_line;
  logic [serial_pkg::NUM_EV-1:0] ev;
  logic [7:0]                  rx_word;

  assign fmt = serial_pkg::decode_fmt(mode_reg);
  assign ext = ctrl_reg[serial_pkg::CTRL_EXT];
  assign te  = ctrl_reg[serial_pkg::CTRL_TE];
  assign re  = ctrl_reg[serial_pkg::CTRL_RE];

  edge_sync rx_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (rxd),
    .level (rx_lvl),
    .rise  (),
    .fall  (rx_fall)
  );

  edge_sync sck_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (sck_in),
    .level (),
    .rise  (sck_rise),
    .fall  (sck_fall)
  );

  // External clock replaces the baud divider as the tick source
  assign tick   = ext ? sck_rise : (bdiv_reg == baud_reg);
  assign adv    = (fmt.sync && ext) ? sck_fall : (tick && ph_reg == serial_pkg::LAST_TICK);
  assign samp   = ext ? sck_rise : (tick && ph_reg == serial_pkg::SAMPLE_TICK);
  assign smp    = tick && tcnt_reg == serial_pkg::SAMPLE_TICK;
  assign bit_in = fmt.sync ? samp : smp;

  tx_shifter tx (
    .clk   (clk),
    .rstn  (rstn),
    .en    (te),
    .adv   (adv),
    .fmt   (fmt),
    .mpb   (ctrl_reg[serial_pkg::CTRL_MPB]),
    .valid (hold_full_reg),
    .data  (hold_reg),
    .take  (take),
    .done  (tx_done),
    .line  (tx_line)
  );

  always_comb begin
    bdiv_next = ext ? '0 : (tick ? '0 : bdiv_reg + 1'b1);
    ph_next   = tick ? ph_reg + 4'h1 : ph_reg;
    pins_next.txd     = te ? tx_line : 1'b1;
    // Low half then high half: rising edge lands at bit centre
    pins_next.sck_out = ph_reg[3];
    pins_next.sck_oe  = !ext && (fmt.sync || ctrl_reg[serial_pkg::CTRL_CKO]);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bdiv_reg <= '0;
      ph_reg   <= 4'h0;
      pins_reg <= '{txd: 1'b1, sck_out: 1'b0, sck_oe: 1'b0};
    end else begin
      bdiv_reg <= bdiv_next;
      ph_reg   <= ph_next;
      pins_reg <= pins_next;
    end
  end

  // Receiver
  assign rx_word = fmt.seven ? {1'b0, rsh_reg[7:1]} : rsh_reg;

  always_comb begin
    rst_next   = rst_reg;
    rsh_next   = rsh_reg;
    rcnt_next  = rcnt_reg;
    tcnt_next  = tick ? tcnt_reg + 4'h1 : tcnt_reg;
    rpar_next  = rpar_reg;
    rdone_next = 1'b0;
    rfe_next   = 1'b0;
    rpe_next   = 1'b0;
    if (!re) begin
      rst_next = R_IDLE;
    end else begin
      unique case (rst_reg)
        R_IDLE: begin
          rcnt_next = 4'h0;
          rpar_next = 1'b0;
          if (fmt.sync) begin
            rst_next = R_DATA;
          end else if (rx_fall) begin
            rst_next  = R_START;
            tcnt_next = 4'h0;
          end
        end
        R_START: begin
          if (smp) begin
            rst_next = rx_lvl ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (bit_in) begin
            rsh_next  = {rx_lvl, rsh_reg[7:1]};
            rpar_next = rpar_reg ^ rx_lvl;
            rcnt_next = rcnt_reg + 4'h1;
            if (rcnt_next == serial_pkg::nbits(fmt)) begin
              rcnt_next = 4'h0;
              rpar_next = 1'b0;
              if (fmt.sync) begin
                rdone_next = 1'b1;
              end else begin
                rpar_next = rpar_reg ^ rx_lvl;
                rst_next  = (fmt.parity || fmt.multi) ? R_PAR : R_STOP;
              end
            end
          end
        end
        R_PAR: begin
          if (smp) begin
            rst_next = R_STOP;
            rpar_next = fmt.parity && ((rpar_reg ^ rx_lvl) != fmt.odd);
          end
        end
        R_STOP: begin
          if (smp) begin
            rst_next   = R_IDLE;
            rdone_next = 1'b1;
            rfe_next   = !rx_lvl;
            rpe_next   = rpar_reg;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_reg   <= R_IDLE;
      rsh_reg   <= 8'h00;
      rcnt_reg  <= 4'h0;
      tcnt_reg  <= 4'h0;
      rpar_reg  <= 1'b0;
      rdone_reg <= 1'b0;
      rfe_reg   <= 1'b0;
      rpe_reg   <= 1'b0;
    end else begin
      rst_reg   <= rst_next;
      rsh_reg   <= rsh_next;
      rcnt_reg  <= rcnt_next;
      tcnt_reg  <= tcnt_next;
      rpar_reg  <= rpar_next;
      rdone_reg <= rdone_next;
      rfe_reg   <= rfe_next;
      rpe_reg   <= rpe_next;
    end
  end

  // Events; a word arriving while the buffer is full is dropped as overrun
  always_comb begin
    ev = '0;
    ev[serial_pkg::EV_TXE]  = take;
    ev[serial_pkg::EV_TEND] = tx_done;
    ev[serial_pkg::EV_RXF]  = rdone_reg && !rx_full_reg;
    ev[serial_pkg::EV_OVERRUN] = rdone_reg && rx_full_reg;
    ev[serial_pkg::EV_FER]  = rdone_reg && !rx_full_reg && rfe_reg && !fmt.sync;
    ev[serial_pkg::EV_PER]  = rdone_reg && !rx_full_reg && rpe_reg && !fmt.sync;
  end

  // Bus slave: one wait cycle, then the answer
  assign acc     = (read || write) && ack_reg;
  assign wr      = acc && write;
  assign rd_stat = acc && read && address == serial_pkg::STAT_OFS;

  always_comb begin
    mode_next      = mode_reg;
    ctrl_next      = ctrl_reg;
    mask_next      = mask_reg;
    baud_next      = baud_reg;
    hold_next      = hold_reg;
    rxbuf_next     = rxbuf_reg;
    ack_next       = (read || write) && !ack_reg;
    wait_next      = !ack_next;
    readdata_next  = readdata_reg;
    // Clear only the bits the read returned, so a fresh event survives
    status_next    = (rd_stat ? status_reg & ~readdata_reg[serial_pkg::NUM_EV-1:0] : status_reg) | ev;
    hold_full_next = (hold_full_reg && !take) || !te ? hold_full_reg && !take && te : 1'b0;
    rx_full_next   = rx_full_reg || ev[serial_pkg::EV_RXF];
    if (ev[serial_pkg::EV_RXF]) begin
      rxbuf_next = rx_word;
    end
    if (read && !ack_reg) begin
      readdata_next = 32'h0000_0000;
      unique case (address)
        serial_pkg::MODE_OFS: readdata_next[7:0] = mode_reg;
        serial_pkg::CTRL_OFS: readdata_next[7:0] = ctrl_reg;
        serial_pkg::MASK_OFS: readdata_next[7:0] = mask_reg;
        serial_pkg::BAUD_OFS: readdata_next[BAUD_W-1:0] = baud_reg;
        serial_pkg::RXD_OFS:  readdata_next[7:0] = rxbuf_reg;
        serial_pkg::STAT_OFS: begin
          readdata_next[serial_pkg::NUM_EV-1:0]    = status_reg;
          readdata_next[serial_pkg::STAT_HOLD_EMPTY] = !hold_full_reg;
          readdata_next[serial_pkg::STAT_RX_FULL]    = rx_full_reg;
        end
        default: readdata_next = 32'h0000_0000;
      endcase
    end
    if (read && ack_reg && address == serial_pkg::RXD_OFS) begin
      rx_full_next = ev[serial_pkg::EV_RXF];
    end
    if (wr) begin
      unique case (address)
        serial_pkg::MODE_OFS: mode_next = writedata[7:0];
        serial_pkg::CTRL_OFS: ctrl_next = writedata[7:0];
        serial_pkg::MASK_OFS: mask_next = writedata[7:0];
        serial_pkg::BAUD_OFS: baud_next = writedata[BAUD_W-1:0];
        serial_pkg::TXD_OFS: begin
          hold_next      = writedata[7:0];
          hold_full_next = te;
        end
        default: ;
      endcase
    end
    irq_next = |(status_next & mask_next[serial_pkg::NUM_EV-1:0]);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_reg      <= serial_pkg::MODE_RST;
      ctrl_reg      <= serial_pkg::CTRL_RST;
      mask_reg      <= serial_pkg::MASK_RST;
      baud_reg      <= serial_pkg::BAUD_RST[BAUD_W-1:0];
      status_reg    <= '0;
      hold_reg      <= 8'h00;
      hold_full_reg <= 1'b0;
      rxbuf_reg     <= 8'h00;
      rx_full_reg   <= 1'b0;
      readdata_reg  <= 32'h0000_0000;
      wait_reg      <= 1'b1;
      ack_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      ctrl_reg      <= ctrl_next;
      mask_reg      <= mask_next;
      baud_reg      <= baud_next;
      status_reg    <= status_next;
      hold_reg      <= hold_next;
      hold_full_reg <= hold_full_next;
      rxbuf_reg     <= rxbuf_next;
      rx_full_reg   <= rx_full_next;
      readdata_reg  <= readdata_next;
      wait_reg      <= wait_next;
      ack_reg       <= ack_next;
      irq_reg       <= irq_next;
    end
  end

  assign readdata    = readdata_reg;
  assign waitrequest = wait_reg;
  assign irq         = irq_reg;
  assign txd         = pins_reg.txd;
  assign sck_out     = pins_reg.sck_out;
  assign sck_oe      = pins_reg.sck_oe;
endmodule

/* core/serial_pkg.sv */
package serial_pkg;

  // Register byte offsets
  localparam logic [4:0] MODE_OFS = 5'h00;
  localparam logic [4:0] CTRL_OFS = 5'h04;
  localparam logic [4:0] STAT_OFS = 5'h08;
  localparam logic [4:0] MASK_OFS = 5'h0c;
  localparam logic [4:0] TXD_OFS  = 5'h10;
  localparam logic [4:0] RXD_OFS  = 5'h14;
  localparam logic [4:0] BAUD_OFS = 5'h18;

  // Mode register fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_CHAR_LEN = 6;
  localparam int MODE_PARITY   = 5;
  localparam int MODE_ODD  = 4;
  localparam int MODE_STOP = 3;
  localparam int MODE_MULTI = 2;

  // Control register fields
  localparam int CTRL_EXT = 1;
  localparam int CTRL_CKO = 0;
  localparam int CTRL_MPB = 2;
  localparam int CTRL_RE  = 4;
  localparam int CTRL_TE  = 5;

  // Status events
  localparam int EV_TXE  = 0;
  localparam int EV_RXF  = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_FER  = 3;
  localparam int EV_PER  = 4;
  localparam int EV_TEND = 5;
  localparam int NUM_EV  = 6;
  localparam int STAT_HOLD_EMPTY = 8;
  localparam int STAT_RX_FULL    = 9;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // Oversampling ticks per bit and sample point
  localparam logic [3:0] LAST_TICK   = 4'hf;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] BITS_8      = 4'h8;
  localparam logic [3:0] BITS_7      = 4'h7;

  typedef struct packed {
    logic sync;
    logic seven;
    logic parity;
    logic odd;
    logic two_stop;
    logic multi;
  } fmt_type;

  typedef struct packed {
    logic txd;
    logic sck_out;
    logic sck_oe;
  } pins_type;

  function automatic fmt_type decode_fmt(input logic [7:0] m);
    fmt_type f;
    f.sync     = m[MODE_SYNC];
    f.seven    = m[MODE_CHAR_LEN] & ~m[MODE_SYNC];
    f.parity   = m[MODE_PARITY] & ~m[MODE_MULTI] & ~m[MODE_SYNC];
    f.odd      = m[MODE_ODD];
    f.two_stop = m[MODE_STOP] & ~m[MODE_SYNC];
    f.multi    = m[MODE_MULTI] & ~m[MODE_SYNC];
    return f;
  endfunction

  function automatic logic [3:0] nbits(input fmt_type f);
    return f.seven ? BITS_7 : BITS_8;
  endfunction

endpackage

/* core/tx_shifter.sv */
`timescale 1ns/1ns
module tx_shifter (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                en,
  input  wire logic                adv,
  input  serial_pkg::fmt_type      fmt,
  input  wire logic                mpb,
  input  wire logic                valid,
  input  wire logic [7:0]          data,
  output logic                     take,
  output logic                     done,
  output logic                     line
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_type;

  tx_state_type st_reg, st_next;
  logic [7:0]   sh_reg, sh_next;
  logic [3:0]   cnt_reg, cnt_next;
  logic         par_reg, par_next;
  logic         line_reg, line_next;
  logic         take_reg, take_next;
  logic         done_reg, done_next;
  logic         pbit;

  assign pbit = fmt.multi ? mpb : ((^(fmt.seven ? {1'b0, data[6:0]} : data)) ^ fmt.odd);

  always_comb begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    par_next  = par_reg;
    line_next = line_reg;
    take_next = 1'b0;
    done_next = 1'b0;
    if (!en) begin
      st_next   = T_IDLE;
      line_next = 1'b1;
    end else if (adv) begin
      unique case (st_reg)
        T_IDLE, T_STOP: begin
          if (st_reg == T_STOP && fmt.two_stop && cnt_reg == 4'h0) begin
            cnt_next = 4'h1;
          end else if (valid) begin
            take_next = 1'b1;
            par_next  = pbit;
            if (fmt.sync) begin
              st_next   = T_DATA;
              line_next = data[0];
              sh_next   = {1'b1, data[7:1]};
              cnt_next  = 4'h1;
            end else begin
              st_next   = T_START;
              line_next = 1'b0;
              sh_next   = data;
            end
          end else begin
            done_next = (st_reg == T_STOP);
            st_next   = T_IDLE;
            line_next = 1'b1;
          end
        end
        T_START: begin
          st_next   = T_DATA;
          line_next = sh_reg[0];
          sh_next   = {1'b1, sh_reg[7:1]};
          cnt_next  = 4'h1;
        end
        T_DATA: begin
          if (cnt_reg != serial_pkg::nbits(fmt)) begin
            line_next = sh_reg[0];
            sh_next   = {1'b1, sh_reg[7:1]};
            cnt_next  = cnt_reg + 4'h1;
          end else if (fmt.sync) begin
            if (valid) begin
              take_next = 1'b1;
              line_next = data[0];
              sh_next   = {1'b1, data[7:1]};
              cnt_next  = 4'h1;
            end else begin
              done_next = 1'b1;
              st_next   = T_IDLE;
              line_next = 1'b1;
            end
          end else if (fmt.parity || fmt.multi) begin
            st_next   = T_PAR;
            line_next = par_reg;
          end else begin
            st_next   = T_STOP;
            line_next = 1'b1;
            cnt_next  = 4'h0;
          end
        end
        T_PAR: begin
          st_next   = T_STOP;
          line_next = 1'b1;
          cnt_next  = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg   <= T_IDLE;
      sh_reg   <= 8'hff;
      cnt_reg  <= 4'h0;
      par_reg  <= 1'b0;
      line_reg <= 1'b1;
      take_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      par_reg  <= par_next;
      line_reg <= line_next;
      take_reg <= take_next;
      done_reg <= done_next;
    end
  end

  assign take = take_reg;
  assign done = done_reg;
  assign line = line_reg;
endmodule
